//--- common/rgta_pkg.sv
`default_nettype none
package rgta_pkg;
  // gain row field layout (row word = {dig_atten_en, dig_word, second, first})
  localparam int FE_W = 6;
  localparam int SN_FE_W = 5;
  localparam int EXT_W = 4;
  localparam int DIG_W = 7;
  localparam int ROW_W = 18;
  localparam int ROW_FE_LSB = 0;
  localparam int ROW_SEC_LSB = 6;
  localparam int ROW_DIG_LSB = 10;
  localparam int ROW_EN_BIT = 17;
  localparam int MAIN_ROWS = 255;
  localparam int OBS_ROWS = 47;
  localparam int SNIF_ROWS = 127;
  localparam logic [7:0] TOP_INDEX = 8'hFF;
  localparam logic [4:0] SN_FE_MAX = 5'h13;
  localparam int GPIO_W = 12;
  // register byte addresses
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_IDX_M1 = 12'h004;
  localparam logic [11:0] ADDR_IDX_M2 = 12'h008;
  localparam logic [11:0] ADDR_IDX_OBS = 12'h00C;
  localparam logic [11:0] ADDR_MAXIDX = 12'h010;
  localparam logic [11:0] ADDR_DEPTH = 12'h014;
  localparam logic [11:0] ADDR_STATUS = 12'h018;
  localparam logic [11:0] ADDR_TBL_ADDR = 12'h01C;
  localparam logic [11:0] ADDR_TBL_DATA = 12'h020;
  localparam logic [11:0] ADDR_OUT_M1 = 12'h024;
  localparam logic [11:0] ADDR_OUT_M2 = 12'h028;
  localparam logic [11:0] ADDR_OUT_OBS = 12'h02C;
  // ctrl fields
  localparam int CTRL_LOOKUP_BIT = 0;
  localparam int CTRL_OE_BIT = 1;
  localparam int CTRL_SNIF_BIT = 2;
  localparam logic [7:0] MAXIDX_RESET = 8'hFF;
  // table select in table address register bits [9:8]
  typedef enum logic [1:0] {RGTA_TBL_M1, RGTA_TBL_M2, RGTA_TBL_OBS, RGTA_TBL_SNIF} rgta_tbl_t;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [1:0] RESP_DECERR = 2'h3;
endpackage
`default_nettype wire

//--- rtl/rgta_table.sv
`timescale 1ns/10ps
`default_nettype none
module rgta_table import rgta_pkg::*; #(
  parameter int DEPTH = 255,
  parameter int AW = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_row,
  input wire logic [ROW_W-1:0] wr_data,
  input wire logic [AW-1:0] rd_row,
  output logic [ROW_W-1:0] rd_data
);
  typedef struct packed {
    logic [DEPTH-1:0][ROW_W-1:0] mem;
  } rgta_tab_state_t;
  rgta_tab_state_t state_reg, state_next;

  always_comb begin
    state_next = state_reg;
    if (wr_en && (int'(wr_row) < DEPTH)) begin
      state_next.mem[wr_row] = wr_data;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign rd_data = (int'(rd_row) < DEPTH) ? state_reg.mem[rd_row] : '0;
endmodule // rgta_table
`default_nettype wire

//--- rtl/rgta_row_apply.sv
`timescale 1ns/10ps
`default_nettype none
module rgta_row_apply import rgta_pkg::*; (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic load,
  input wire logic sniffer,
  input wire logic [ROW_W-1:0] row,
  output logic [FE_W-1:0] fe_atten,
  output logic [EXT_W-1:0] ext_atten,
  output logic lna_bypass,
  output logic [DIG_W-1:0] dig_word,
  output logic dig_atten_en
);
  typedef struct packed {
    logic [FE_W-1:0] fe;
    logic [EXT_W-1:0] ext;
    logic byp;
    logic [DIG_W-1:0] dig;
    logic en;
  } rgta_ctl_t;
  rgta_ctl_t state_reg, state_next;

  always_comb begin
    state_next = state_reg;
    if (load) begin
      // all five fields move in the same edge
      if (sniffer) begin
        state_next.fe = {1'b0, row[ROW_FE_LSB +: SN_FE_W]};
        if (row[ROW_FE_LSB +: SN_FE_W] > SN_FE_MAX) begin
          state_next.fe = {1'b0, SN_FE_MAX};
        end
        state_next.byp = row[ROW_SEC_LSB];
        state_next.ext = '0;
      end else begin
        state_next.fe = row[ROW_FE_LSB +: FE_W];
        state_next.ext = row[ROW_SEC_LSB +: EXT_W];
        state_next.byp = 1'b0;
      end
      state_next.dig = row[ROW_DIG_LSB +: DIG_W];
      state_next.en = row[ROW_EN_BIT];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign fe_atten = state_reg.fe;
  assign ext_atten = state_reg.ext;
  assign lna_bypass = state_reg.byp;
  assign dig_word = state_reg.dig;
  assign dig_atten_en = state_reg.en;
endmodule // rgta_row_apply
`default_nettype wire

//--- rtl/rgta_top.sv
// Implementation choices: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module rgta_top import rgta_pkg::*; (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic agc_m1_valid,
  input wire logic [7:0] agc_m1_index,
  input wire logic agc_m2_valid,
  input wire logic [7:0] agc_m2_index,
  input wire logic agc_snif_valid,
  input wire logic [7:0] agc_snif_index,
  output logic [GPIO_W-1:0] gpio3v3_out,
  output logic [GPIO_W-1:0] gpio3v3_oe,
  output logic [FE_W-1:0] m1_fe_atten,
  output logic [DIG_W-1:0] m1_dig_word,
  output logic m1_dig_atten_en,
  output logic [FE_W-1:0] m2_fe_atten,
  output logic [DIG_W-1:0] m2_dig_word,
  output logic m2_dig_atten_en,
  output logic [FE_W-1:0] obs_fe_atten,
  output logic [DIG_W-1:0] obs_dig_word,
  output logic obs_dig_atten_en,
  output logic obs_lna_bypass
);
  //////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic aw_got;
    logic [11:0] awaddr;
    logic w_got;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [2:0] ctrl;
    logic [7:0] idx_m1;
    logic [7:0] idx_m2;
    logic [7:0] idx_obs;
    logic [7:0] max_m1;
    logic [7:0] max_m2;
    logic [7:0] dep_m1;
    logic [7:0] dep_m2;
    logic [7:0] dep_obs;
    logic [7:0] dep_snif;
    logic [3:0] rejected;
    logic [9:0] tbl_addr;
    logic [3:0] load;
  } rgta_state_t;
  rgta_state_t state_reg, state_next;

  logic [3:0] tbl_we;
  logic [ROW_W-1:0] row_m1, row_m2, row_obs, row_snif;
  logic [7:0] rrow_m1, rrow_m2, rrow_obs;
  logic [EXT_W-1:0] ext_m1, ext_m2, ext_obs;
  logic [FE_W-1:0] obs_fe_sel;
  logic obs_byp;

  // row address from index
  function automatic logic [7:0] rgta_row_of(input logic [7:0] idx);
    rgta_row_of = TOP_INDEX - idx;
  endfunction

  function automatic logic rgta_ok(input logic [7:0] idx, input logic [7:0] depth,
                                   input logic [7:0] maxi);
    rgta_ok = (idx <= maxi) && (rgta_row_of(idx) < depth);
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  always_comb begin
    logic do_wr;
    logic [7:0] v;
    logic [7:0] obs_dep;
    do_wr = 1'b0;
    v = '0;
    obs_dep = '0;
    state_next = state_reg;
    state_next.load = '0;
    tbl_we = '0;
    if (s_axi_awvalid && s_axi_awready) begin
      state_next.aw_got = 1'b1;
      state_next.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      state_next.w_got = 1'b1;
      state_next.wdata = s_axi_wdata;
      state_next.wstrb = s_axi_wstrb;
    end
    if (s_axi_bvalid && s_axi_bready) begin
      state_next.bvalid = 1'b0;
    end
    obs_dep = state_reg.ctrl[CTRL_SNIF_BIT] ? state_reg.dep_snif : state_reg.dep_obs;
    // register write once address and data are both held
    if (state_reg.aw_got && state_reg.w_got && !state_reg.bvalid) begin
      do_wr = 1'b1;
      state_next.aw_got = 1'b0;
      state_next.w_got = 1'b0;
      state_next.bvalid = 1'b1;
      state_next.bresp = RESP_OKAY;
    end
    v = state_reg.wdata[7:0];
    if (do_wr && state_reg.wstrb[0]) begin
      if (state_reg.awaddr == ADDR_CTRL) begin
        state_next.ctrl = state_reg.wdata[2:0];
        if (state_reg.wdata[CTRL_SNIF_BIT] != state_reg.ctrl[CTRL_SNIF_BIT]) begin
          state_next.load[2] = 1'b1;
        end
      end else if (state_reg.awaddr == ADDR_IDX_M1) begin
        if (rgta_ok(v, state_reg.dep_m1, state_reg.max_m1)) begin
          state_next.idx_m1 = v;
          state_next.load[0] = 1'b1;
        end else begin
          state_next.rejected[0] = 1'b1;
          state_next.bresp = RESP_SLVERR;
        end
      end else if (state_reg.awaddr == ADDR_IDX_M2) begin
        if (rgta_ok(v, state_reg.dep_m2, state_reg.max_m2)) begin
          state_next.idx_m2 = v;
          state_next.load[1] = 1'b1;
        end else begin
          state_next.rejected[1] = 1'b1;
          state_next.bresp = RESP_SLVERR;
        end
      end else if (state_reg.awaddr == ADDR_IDX_OBS) begin
        if (rgta_ok(v, obs_dep, TOP_INDEX)) begin
          state_next.idx_obs = v;
          state_next.load[2] = 1'b1;
        end else begin
          state_next.rejected[2] = 1'b1;
          state_next.bresp = RESP_SLVERR;
        end
      end else if (state_reg.awaddr == ADDR_MAXIDX) begin
        state_next.max_m1 = state_reg.wdata[7:0];
        state_next.max_m2 = state_reg.wdata[15:8];
      end else if (state_reg.awaddr == ADDR_DEPTH) begin
        state_next.dep_m1 = (state_reg.wdata[7:0] > 8'(MAIN_ROWS)) ? 8'(MAIN_ROWS)
                            : state_reg.wdata[7:0];
        state_next.dep_m2 = (state_reg.wdata[15:8] > 8'(MAIN_ROWS)) ? 8'(MAIN_ROWS)
                            : state_reg.wdata[15:8];
        state_next.dep_obs = (state_reg.wdata[23:16] > 8'(OBS_ROWS)) ? 8'(OBS_ROWS)
                             : state_reg.wdata[23:16];
        state_next.dep_snif = (state_reg.wdata[31:24] > 8'(SNIF_ROWS)) ? 8'(SNIF_ROWS)
                              : state_reg.wdata[31:24];
      end else if (state_reg.awaddr == ADDR_STATUS) begin
        state_next.rejected = state_reg.rejected & ~state_reg.wdata[3:0];
      end else if (state_reg.awaddr == ADDR_TBL_ADDR) begin
        state_next.tbl_addr = state_reg.wdata[9:0];
      end else if (state_reg.awaddr == ADDR_TBL_DATA) begin
        tbl_we[state_reg.tbl_addr[9:8]] = 1'b1;
        state_next.tbl_addr[7:0] = state_reg.tbl_addr[7:0] + 8'h01;
      end else if (state_reg.awaddr > ADDR_OUT_OBS) begin
        state_next.bresp = RESP_DECERR;
      end
    end
    // automatic index updates; observation path is driven here only by the sniffer index, in sniffer mode
    if (agc_m1_valid && rgta_ok(agc_m1_index, state_reg.dep_m1, state_reg.max_m1)) begin
      state_next.idx_m1 = agc_m1_index;
      state_next.load[0] = 1'b1;
    end
    if (agc_m2_valid && rgta_ok(agc_m2_index, state_reg.dep_m2, state_reg.max_m2)) begin
      state_next.idx_m2 = agc_m2_index;
      state_next.load[1] = 1'b1;
    end
    if (agc_snif_valid && state_reg.ctrl[CTRL_SNIF_BIT]
        && rgta_ok(agc_snif_index, state_reg.dep_snif, TOP_INDEX)) begin
      state_next.idx_obs = agc_snif_index;
      state_next.load[2] = 1'b1;
    end
    // read side
    if (s_axi_rvalid && s_axi_rready) begin
      state_next.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      state_next.rvalid = 1'b1;
      state_next.rresp = RESP_OKAY;
      state_next.rdata = '0;
      if (s_axi_araddr == ADDR_CTRL) begin
        state_next.rdata = {29'h0, state_reg.ctrl};
      end else if (s_axi_araddr == ADDR_IDX_M1) begin
        state_next.rdata = {24'h0, state_reg.idx_m1};
      end else if (s_axi_araddr == ADDR_IDX_M2) begin
        state_next.rdata = {24'h0, state_reg.idx_m2};
      end else if (s_axi_araddr == ADDR_IDX_OBS) begin
        state_next.rdata = {24'h0, state_reg.idx_obs};
      end else if (s_axi_araddr == ADDR_MAXIDX) begin
        state_next.rdata = {16'h0, state_reg.max_m2, state_reg.max_m1};
      end else if (s_axi_araddr == ADDR_DEPTH) begin
        state_next.rdata = {state_reg.dep_snif, state_reg.dep_obs, state_reg.dep_m2,
                            state_reg.dep_m1};
      end else if (s_axi_araddr == ADDR_STATUS) begin
        state_next.rdata = {28'h0, state_reg.rejected};
      end else if (s_axi_araddr == ADDR_TBL_ADDR) begin
        state_next.rdata = {22'h0, state_reg.tbl_addr};
      end else if (s_axi_araddr == ADDR_TBL_DATA) begin
        state_next.rdata = '0;
      end else if (s_axi_araddr == ADDR_OUT_M1) begin
        state_next.rdata = {14'h0, m1_dig_atten_en, m1_dig_word, ext_m1, m1_fe_atten};
      end else if (s_axi_araddr == ADDR_OUT_M2) begin
        state_next.rdata = {14'h0, m2_dig_atten_en, m2_dig_word, ext_m2, m2_fe_atten};
      end else if (s_axi_araddr == ADDR_OUT_OBS) begin
        state_next.rdata = {13'h0, obs_lna_bypass, obs_dig_atten_en, obs_dig_word, ext_obs,
                            obs_fe_atten};
      end else begin
        state_next.rresp = RESP_DECERR;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= '0;
      state_reg.idx_m1 <= TOP_INDEX;
      state_reg.idx_m2 <= TOP_INDEX;
      state_reg.idx_obs <= TOP_INDEX;
      state_reg.max_m1 <= MAXIDX_RESET;
      state_reg.max_m2 <= MAXIDX_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  assign s_axi_awready = !state_reg.aw_got;
  assign s_axi_wready = !state_reg.w_got;
  assign s_axi_bvalid = state_reg.bvalid;
  assign s_axi_bresp = state_reg.bresp;
  assign s_axi_arready = !state_reg.rvalid;
  assign s_axi_rvalid = state_reg.rvalid;
  assign s_axi_rdata = state_reg.rdata;
  assign s_axi_rresp = state_reg.rresp;

  //////////////////////////////////////////////////////////////////////////////
  assign rrow_m1 = rgta_row_of(state_reg.idx_m1);
  assign rrow_m2 = rgta_row_of(state_reg.idx_m2);
  assign rrow_obs = rgta_row_of(state_reg.idx_obs);

  rgta_table #(.DEPTH(MAIN_ROWS), .AW(8)) u_tbl_m1 (
    .aclk(aclk), .aresetn(aresetn), .wr_en(tbl_we[RGTA_TBL_M1]),
    .wr_row(state_reg.tbl_addr[7:0]), .wr_data(state_reg.wdata[ROW_W-1:0]),
    .rd_row(rrow_m1), .rd_data(row_m1));
  rgta_table #(.DEPTH(MAIN_ROWS), .AW(8)) u_tbl_m2 (
    .aclk(aclk), .aresetn(aresetn), .wr_en(tbl_we[RGTA_TBL_M2]),
    .wr_row(state_reg.tbl_addr[7:0]), .wr_data(state_reg.wdata[ROW_W-1:0]),
    .rd_row(rrow_m2), .rd_data(row_m2));
  rgta_table #(.DEPTH(OBS_ROWS), .AW(8)) u_tbl_obs (
    .aclk(aclk), .aresetn(aresetn), .wr_en(tbl_we[RGTA_TBL_OBS]),
    .wr_row(state_reg.tbl_addr[7:0]), .wr_data(state_reg.wdata[ROW_W-1:0]),
    .rd_row(rrow_obs), .rd_data(row_obs));
  rgta_table #(.DEPTH(SNIF_ROWS), .AW(8)) u_tbl_snif (
    .aclk(aclk), .aresetn(aresetn), .wr_en(tbl_we[RGTA_TBL_SNIF]),
    .wr_row(state_reg.tbl_addr[7:0]), .wr_data(state_reg.wdata[ROW_W-1:0]),
    .rd_row(rrow_obs), .rd_data(row_snif));

  // element controls; analog stages map the codes to dB
  rgta_row_apply u_app_m1 (
    .aclk(aclk), .aresetn(aresetn), .load(state_reg.load[0]), .sniffer(1'b0),
    .row(row_m1), .fe_atten(m1_fe_atten), .ext_atten(ext_m1), .lna_bypass(),
    .dig_word(m1_dig_word), .dig_atten_en(m1_dig_atten_en));
  rgta_row_apply u_app_m2 (
    .aclk(aclk), .aresetn(aresetn), .load(state_reg.load[1]), .sniffer(1'b0),
    .row(row_m2), .fe_atten(m2_fe_atten), .ext_atten(ext_m2), .lna_bypass(),
    .dig_word(m2_dig_word), .dig_atten_en(m2_dig_atten_en));
  rgta_row_apply u_app_obs (
    .aclk(aclk), .aresetn(aresetn), .load(state_reg.load[2]),
    .sniffer(state_reg.ctrl[CTRL_SNIF_BIT]),
    .row(state_reg.ctrl[CTRL_SNIF_BIT] ? row_snif : row_obs),
    .fe_atten(obs_fe_sel), .ext_atten(ext_obs), .lna_bypass(obs_byp),
    .dig_word(obs_dig_word), .dig_atten_en(obs_dig_atten_en));
  assign obs_fe_atten = obs_fe_sel;
  assign obs_lna_bypass = obs_byp;

  //////////////////////////////////////////////////////////////////////////////
  // pin 7 is claimed by both main two and observation; observation takes it
  always_comb begin
    gpio3v3_out = '0;
    gpio3v3_oe = '0;
    if (state_reg.ctrl[CTRL_LOOKUP_BIT] && state_reg.ctrl[CTRL_OE_BIT]) begin
      gpio3v3_out[3:0] = ext_m1;
      gpio3v3_out[7:4] = ext_m2;
      gpio3v3_out[11:7] = {1'b0, ext_obs};
      gpio3v3_oe = '1;
    end
  end
endmodule // rgta_top
`default_nettype wire

//--- dv/rgta_step_atten_model.sv
`timescale 1ns/10ps
`default_nettype none
module rgta_step_atten_model import rgta_pkg::*; (
  input wire logic [GPIO_W-1:0] pins,
  input wire logic [GPIO_W-1:0] pins_oe,
  output logic [EXT_W-1:0] m1_step,
  output logic [EXT_W-1:0] m2_step,
  output logic [EXT_W-1:0] obs_step
);
  // released control lines float high: full attenuation
  assign m1_step = &pins_oe[3:0] ? pins[3:0] : 4'hF;
  assign m2_step = &pins_oe[7:4] ? pins[7:4] : 4'hF;
  assign obs_step = &pins_oe[10:7] ? pins[10:7] : 4'hF;
endmodule // rgta_step_atten_model
`default_nettype wire

//--- dv/rgta_top_props.sv
`timescale 1ns/10ps
`default_nettype none
module rgta_top_props import rgta_pkg::*; (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic agc_m1_valid,
  input wire logic [GPIO_W-1:0] gpio3v3_out,
  input wire logic [GPIO_W-1:0] gpio3v3_oe,
  input wire logic [FE_W-1:0] m1_fe_atten,
  input wire logic [DIG_W-1:0] m1_dig_word,
  input wire logic m1_dig_atten_en
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped before taken");
  rresp_hold_a: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rresp))
    else $error("read response changed before taken");
  write_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##2 s_axi_bvalid) else $error("write response late");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read response late");
  unmapped_read_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > ADDR_OUT_OBS
    |=> s_axi_rresp == RESP_DECERR) else $error("unmapped read not refused");
  pin_idle_a: assert property (gpio3v3_oe == '0 |-> gpio3v3_out == '0)
    else $error("pins driven while released");
  oe_whole_a: assert property (gpio3v3_oe == '0 || gpio3v3_oe == '1)
    else $error("pin enables split");
  top_pin_a: assert property (gpio3v3_out[11] == 1'h0)
    else $error("pin 11 not low");
  row_atomic_a: assert property ($changed({m1_fe_atten, m1_dig_word, m1_dig_atten_en})
    |-> $past(s_axi_bvalid) || $past(agc_m1_valid) || $past(agc_m1_valid, 2))
    else $error("main one controls changed without a new index");
endmodule // rgta_top_props
bind rgta_top rgta_top_props chk (.*);
`default_nettype wire

//--- dv/rgta_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module rgta_tb_top import rgta_pkg::*;;
  function automatic logic [31:0] row(input logic en, input logic [6:0] dg,
                                      input logic [3:0] ex, input logic [5:0] fe);
    return {14'h0, en, dg, ex, fe};
  endfunction
  localparam logic [31:0] ROWS [4][2] = '{
    '{row(1'h1, 7'h55, 4'hA, 6'h3F), row(1'h0, 7'h2A, 4'h5, 6'h00)},
    '{row(1'h0, 7'h7F, 4'h3, 6'h15), row(1'h1, 7'h01, 4'hC, 6'h2A)},
    '{row(1'h1, 7'h11, 4'h9, 6'h07), row(1'h0, 7'h03, 4'h6, 6'h01)},
    '{row(1'h0, 7'h22, 4'h1, 6'h1F), row(1'h1, 7'h0F, 4'h0, 6'h03)}};
  localparam logic [31:0] MSK = 32'h0007FC3F;
  logic aclk = 1'h0, aresetn = 1'h0;
  logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic [31:0] s_axi_wdata = '0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic agc_m1_valid = 1'h0, agc_m2_valid = 1'h0, agc_snif_valid = 1'h0;
  logic [7:0] agc_m1_index = '0, agc_m2_index = '0, agc_snif_index = '0;
  logic [GPIO_W-1:0] gpio3v3_out, gpio3v3_oe;
  logic [FE_W-1:0] m1_fe_atten, m2_fe_atten, obs_fe_atten;
  logic [DIG_W-1:0] m1_dig_word, m2_dig_word, obs_dig_word;
  logic m1_dig_atten_en, m2_dig_atten_en, obs_dig_atten_en, obs_lna_bypass;
  logic [EXT_W-1:0] m1_step, m2_step, obs_step;
  logic [31:0] e1 = '0, e2 = '0, e3 = '0;
  int num_errors = 0, checks = 0;
  always #10 aclk = ~aclk;
  rgta_top uut (.*);
  rgta_step_atten_model step_model (.pins(gpio3v3_out), .pins_oe(gpio3v3_oe),
    .m1_step(m1_step), .m2_step(m2_step), .obs_step(obs_step));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    logic pend;
    pend = 1'h1;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    while (pend) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bready <= 1'h0;
        cmp("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
        pend = 1'h0;
      end
    end
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic pend;
    pend = 1'h1;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    while (pend) begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rready <= 1'h0;
        cmp("rdata", ed, s_axi_rdata);
        cmp("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
        pend = 1'h0;
      end
    end
  endtask
  task automatic agc(input int s, input logic [7:0] i);
    @(posedge aclk);
    {agc_snif_valid, agc_m2_valid, agc_m1_valid} <= 3'(1 << s);
    agc_m1_index <= i;
    agc_m2_index <= i;
    agc_snif_index <= i;
    @(posedge aclk);
    {agc_snif_valid, agc_m2_valid, agc_m1_valid} <= 3'h0;
    @(posedge aclk);
  endtask
  task automatic ports();
    @(negedge aclk);
    cmp("m1_ctl", e1 & MSK, {14'h0, m1_dig_atten_en, m1_dig_word, 4'h0, m1_fe_atten});
    cmp("m2_ctl", e2 & MSK, {14'h0, m2_dig_atten_en, m2_dig_word, 4'h0, m2_fe_atten});
    cmp("obs_ctl", e3 & MSK,
        {13'h0, obs_lna_bypass, obs_dig_atten_en, obs_dig_word, 4'h0, obs_fe_atten});
  endtask
  task automatic report_and_stop();
    if (num_errors == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (5000) @(posedge aclk);
    num_errors++;
    report_and_stop();
  end
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'h1;
    rd(ADDR_MAXIDX, 32'h0000FFFF, RESP_OKAY);
    rd(ADDR_IDX_M1, 32'h000000FF, RESP_OKAY);
    ports();
    cmp("pin_oe", 32'h0, {20'h0, gpio3v3_oe});
    cmp("step_idle", 32'hFFF, {20'h0, obs_step, m2_step, m1_step});
    wr(ADDR_IDX_M1, 32'hFF, RESP_SLVERR);
    rd(ADDR_STATUS, 32'h1, RESP_OKAY);
    wr(ADDR_STATUS, 32'h7, RESP_OKAY);
    rd(ADDR_STATUS, 32'h0, RESP_OKAY);
    wr(ADDR_DEPTH, 32'hFFFFFFFF, RESP_OKAY);
    rd(ADDR_DEPTH, 32'h7F2FFFFF, RESP_OKAY);
    wr(ADDR_DEPTH, 32'h01010202, RESP_OKAY);
    for (int t = 0; t < 4; t++) begin
      wr(ADDR_TBL_ADDR, 32'(t) << 8, RESP_OKAY);
      wr(ADDR_TBL_DATA, ROWS[t][0], RESP_OKAY);
      wr(ADDR_TBL_DATA, ROWS[t][1], RESP_OKAY);
    end
    wr(ADDR_IDX_M1, 32'hFF, RESP_OKAY);
    e1 = ROWS[0][0];
    ports();
    wr(ADDR_IDX_M1, 32'hFE, RESP_OKAY);
    wr(ADDR_IDX_M2, 32'hFE, RESP_OKAY);
    e1 = ROWS[0][1];
    e2 = ROWS[1][1];
    ports();
    rd(ADDR_OUT_M1, ROWS[0][1], RESP_OKAY);
    wr(ADDR_CTRL, 32'h1, RESP_OKAY);
    cmp("pin_oe", 32'h0, {20'h0, gpio3v3_oe});
    wr(ADDR_CTRL, 32'h3, RESP_OKAY);
    wr(ADDR_IDX_OBS, 32'hFF, RESP_OKAY);
    e3 = ROWS[2][0];
    ports();
    cmp("pin_oe", 32'hFFF, {20'h0, gpio3v3_oe});
    cmp("pins", {21'h0, ROWS[2][0][9:6], ROWS[1][1][8:6], ROWS[0][1][9:6]},
        {20'h0, gpio3v3_out});
    cmp("step_pins", {20'h0, ROWS[2][0][9:6], ROWS[2][0][6], ROWS[1][1][8:6], ROWS[0][1][9:6]},
        {20'h0, obs_step, m2_step, m1_step});
    wr(ADDR_IDX_M1, 32'hFD, RESP_SLVERR);
    agc(0, 8'hFF);
    agc(1, 8'hFF);
    agc(0, 8'hC8);
    e1 = ROWS[0][0];
    e2 = ROWS[1][0];
    ports();
    rd(ADDR_STATUS, 32'h1, RESP_OKAY);
    wr(ADDR_MAXIDX, 32'h0000FFFE, RESP_OKAY);
    wr(ADDR_IDX_M1, 32'hFF, RESP_SLVERR);
    wr(ADDR_IDX_M2, 32'hFE, RESP_OKAY);
    e2 = ROWS[1][1];
    ports();
    wr(ADDR_CTRL, 32'h7, RESP_OKAY);
    wr(ADDR_IDX_OBS, 32'hFF, RESP_OKAY);
    agc(2, 8'hFE);
    e3 = row(1'h0, 7'h22, 4'h0, {1'h0, SN_FE_MAX}) | 32'h00040000;
    ports();
    cmp("pins_snif", 32'h0, {29'h0, gpio3v3_out[10:8]});
    wr(ADDR_DEPTH, 32'h02010202, RESP_OKAY);
    agc(2, 8'hFE);
    e3 = ROWS[3][1];
    ports();
    rd(12'h030, 32'h0, RESP_DECERR);
    wr(12'h040, 32'h0, RESP_DECERR);
    report_and_stop();
  end
endmodule // rgta_tb_top
`default_nettype wire
